// ==== adc_regs.svh ====
// Operation
// RQ1: justify bit one right, zero left result
// RQ2: reference bit one external pin, zero supply
// RQ3: bit 5 of main control reads zero
// RQ4: channel field binary index, 000 to 111
// RQ5: writing go one starts conversion, reads one
// RQ6: hardware clears go when conversion finishes
// RQ7: power bit one runs converter, zero off
// RQ8: clock config at 9Fh, three-bit select field
// RQ9: completion clears go, sets flag, interrupts
// RQ10: abort keeps result, waits 2 bit periods
// RQ11: software sets go only once already powered
`ifndef ADC_REGS_SVH
`define ADC_REGS_SVH

// register indexes; byte address is index times four
`define MAIN_IDX 8'h1f
`define CLKCFG_IDX 8'h9f
`define STAT_IDX 8'h20
`define MASK_IDX 8'h21
`define RESULT_IDX 8'h22

// main control field positions
`define JUST_BIT 7
`define REF_BIT 6
`define UNUSED_BIT 5
`define CHS_HI 4
`define CHS_LO 2
`define GO_BIT 1
`define PWR_BIT 0

// clock config field positions
`define CLKSEL_HI 6
`define CLKSEL_LO 4

// status and mask bits
`define DONE_BIT 0
`define ABORT_BIT 1

// reset values
`define MAIN_RST 8'h00
`define CLKCFG_RST 3'h0
`define IRQ_RST 2'h0

// timing
`define CLK_PERIOD_NS 25
`define RC_TAD_NS 4000
`define RC_TAD_CYC ((`RC_TAD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ABORT_TADS 2

`endif

// ==== adc_pkg.sv ====
package adc_pkg;

	// conversion sequencing states
	typedef enum logic [1:0] {st_idle, st_convert, st_holdoff} conv_state_e;

	// controls toward the analog core
	typedef struct packed {
		logic power_on;
		logic ref_ext;
		logic [2:0] channel;
		logic start;
		logic abort;
		logic acq_start;
	} conv_ctrl_s;

	typedef logic [7:0] reg8_t;

endpackage

// ==== tad_timer.sv ====
`timescale 1ns/10ps
`include "adc_regs.svh"
module tad_timer #(
	parameter int CNT_W = 10,
	parameter int RC_CYC = `RC_TAD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [2:0] clk_select,
	input wire logic arm,
	output logic busy,
	output logic fire
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] load;

	// cycles in one bit period for each clock select code
	function automatic logic [CNT_W-1:0] tad_cycles(input logic [2:0] sel);
		logic [CNT_W-1:0] n;
		n = CNT_W'(RC_CYC);
		unique case (sel)
			3'h0: n = CNT_W'(2);
			3'h4: n = CNT_W'(4);
			3'h1: n = CNT_W'(8);
			3'h5: n = CNT_W'(16);
			3'h2: n = CNT_W'(32);
			3'h6: n = CNT_W'(64);
			3'h3, 3'h7: n = CNT_W'(RC_CYC);
		endcase
		return n;
	endfunction

	assign load = CNT_W'(`ABORT_TADS * tad_cycles(clk_select) - 1);

	// counts the post-abort delay down to a single fire pulse
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= '0;
			busy <= 1'b0;
			fire <= 1'b0;
		end
		else
		begin
			fire <= busy && cnt_q == '0;
			busy <= arm || (busy && cnt_q != '0);
			cnt_q <= arm ? load : (busy && cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
		end
	end
endmodule // tad_timer

// ==== result_formatter.sv ====
`timescale 1ns/10ps
module result_formatter #(
	parameter int RAW_W = 10,
	parameter int PAIR_W = 16
) (
	input wire logic right_justify,
	input wire logic [RAW_W-1:0] raw,
	output logic [PAIR_W-1:0] pair
);
	// place the raw result at the bottom or top of the pair
	assign pair = right_justify ? {{(PAIR_W-RAW_W){1'b0}}, raw}
		: {raw, {(PAIR_W-RAW_W){1'b0}}};
endmodule // result_formatter

// ==== adc_control_registers.sv ====
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "adc_regs.svh"
module adc_control_registers #(
	parameter int RAW_W = 10,
	parameter int RC_CYC = `RC_TAD_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conv_done,
	input wire logic [RAW_W-1:0] conv_data,
	output adc_pkg::conv_ctrl_s ctrl,
	output logic irq
);
	adc_pkg::conv_state_e state_q;
	adc_pkg::conv_state_e state_d;
	logic just_q;
	logic just_d;
	logic ref_q;
	logic ref_d;
	logic [2:0] chs_q;
	logic [2:0] chs_d;
	logic pwr_q;
	logic pwr_d;
	logic [2:0] clksel_q;
	logic [2:0] clksel_d;
	logic [1:0] stat_q;
	logic [1:0] stat_d;
	logic [1:0] mask_q;
	logic [1:0] mask_d;
	logic [15:0] result_q;
	logic [15:0] result_d;
	logic [15:0] formatted;
	logic start_d;
	logic abort_d;
	logic acq_d;
	logic acc_phase;
	logic first_acc;
	logic xfer;
	logic hit_main;
	logic hit_clk;
	logic hit_stat;
	logic hit_mask;
	logic hit_res;
	logic hit_any;
	logic wr_main;
	logic wr_clk;
	logic wr_stat;
	logic wr_mask;
	logic go_wr1;
	logic go_wr0;
	logic go_rd;
	logic done_evt;
	logic [1:0] stat_set;
	logic [1:0] stat_clr;
	adc_pkg::reg8_t main_rd;
	adc_pkg::reg8_t clk_rd;
	logic [31:0] rd_word;
	logic tad_busy;
	logic tad_fire;

	// byte address of a register index
	function automatic logic [11:0] addr_of(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction

	// apb phases: one wait state, then completion
	assign acc_phase = psel && penable;
	assign first_acc = acc_phase && !pready;
	assign xfer = acc_phase && pready;

	// address decode
	assign hit_main = paddr == addr_of(`MAIN_IDX);
	assign hit_clk = paddr == addr_of(`CLKCFG_IDX); // [RQ8]
	assign hit_stat = paddr == addr_of(`STAT_IDX);
	assign hit_mask = paddr == addr_of(`MASK_IDX);
	assign hit_res = paddr == addr_of(`RESULT_IDX);
	assign hit_any = hit_main || hit_clk || hit_stat || hit_mask || hit_res;

	// write strobes, effective only at the completing edge
	assign wr_main = xfer && pwrite && hit_main;
	assign wr_clk = xfer && pwrite && hit_clk;
	assign wr_stat = xfer && pwrite && hit_stat;
	assign wr_mask = xfer && pwrite && hit_mask;
	assign go_wr1 = wr_main && pwdata[`GO_BIT]; // [RQ5]
	assign go_wr0 = wr_main && !pwdata[`GO_BIT];

	// go reads one only while a conversion runs
	assign go_rd = state_q == adc_pkg::st_convert; // [RQ5] [RQ6]
	assign done_evt = go_rd && conv_done;

	// read views; unimplemented positions read zero
	assign main_rd = {just_q, ref_q, 1'b0, chs_q, go_rd, pwr_q}; // [RQ3]
	assign clk_rd = {1'b0, clksel_q, 4'h0}; // [RQ8]
	assign rd_word = hit_main ? {24'h0, main_rd}
		: hit_clk ? {24'h0, clk_rd}
		: hit_stat ? {30'h0, stat_q}
		: hit_mask ? {30'h0, mask_q}
		: hit_res ? {16'h0, result_q}
		: 32'h0;

	// next values of the settings; bit 5 has no storage
	assign just_d = wr_main ? pwdata[`JUST_BIT] : just_q; // [RQ1]
	assign ref_d = wr_main ? pwdata[`REF_BIT] : ref_q; // [RQ2]
	assign chs_d = wr_main ? pwdata[`CHS_HI:`CHS_LO] : chs_q; // [RQ4]
	assign pwr_d = wr_main ? pwdata[`PWR_BIT] : pwr_q; // [RQ7]
	assign clksel_d = wr_clk ? pwdata[`CLKSEL_HI:`CLKSEL_LO] : clksel_q; // [RQ8]

	// sticky flags: set wins over write-one-to-clear
	assign stat_set = {abort_d, done_evt}; // [RQ9]
	assign stat_clr = wr_stat ? pwdata[1:0] : 2'h0;
	assign stat_d = (stat_q & ~stat_clr) | stat_set;
	assign mask_d = wr_mask ? pwdata[1:0] : mask_q;

	// only a completed conversion updates the result pair
	assign result_d = done_evt ? formatted : result_q; // [RQ10]

	result_formatter #(
		.RAW_W(RAW_W),
		.PAIR_W(16)
	) u_fmt (
		.right_justify(just_q), // [RQ1]
		.raw(conv_data),
		.pair(formatted)
	);

	tad_timer #(
		.CNT_W(10),
		.RC_CYC(RC_CYC)
	) u_tad (
		.clk(clk),
		.rst_n(rst_n),
		.clk_select(clksel_q),
		.arm(abort_d),
		.busy(tad_busy),
		.fire(tad_fire)
	);

	// conversion sequencing
	always_comb
	begin
		state_d = state_q;
		start_d = 1'b0;
		abort_d = 1'b0;
		acq_d = 1'b0;
		unique case (state_q)
			adc_pkg::st_idle:
				if (go_wr1 && pwr_q && pwr_d) // [RQ7] no start in a power-off write
				begin
					state_d = adc_pkg::st_convert; // [RQ5]
					start_d = 1'b1;
				end
			adc_pkg::st_convert:
				if (conv_done)
				begin
					state_d = adc_pkg::st_idle; // [RQ6] [RQ9]
				end
				else if (go_wr0 || !pwr_d)
				begin
					state_d = adc_pkg::st_holdoff; // [RQ10] [RQ7]
					abort_d = 1'b1;
				end
			adc_pkg::st_holdoff:
				if (tad_fire)
				begin
					state_d = adc_pkg::st_idle; // [RQ10]
					acq_d = 1'b1;
				end
		endcase
	end

	// settings and state
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_q <= adc_pkg::st_idle;
			{just_q, ref_q} <= 2'h0;
			chs_q <= 3'h0;
			pwr_q <= 1'b0;
			clksel_q <= `CLKCFG_RST;
		end
		else
		begin
			state_q <= state_d;
			{just_q, ref_q} <= {just_d, ref_d};
			chs_q <= chs_d;
			pwr_q <= pwr_d;
			clksel_q <= clksel_d;
		end
	end

	// flags, result and interrupt line
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stat_q <= `IRQ_RST;
			mask_q <= `IRQ_RST;
			result_q <= 16'h0;
			irq <= 1'b0;
		end
		else
		begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			result_q <= result_d;
			irq <= |(stat_d & mask_d); // [RQ9]
		end
	end

	// apb answer
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end
		else
		begin
			pready <= first_acc;
			pslverr <= first_acc && !hit_any;
			prdata <= (first_acc && !pwrite) ? rd_word : prdata;
		end
	end

	// analog core controls
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			ctrl <= '0;
		end
		else
		begin
			ctrl.power_on <= pwr_d; // [RQ7]
			ctrl.ref_ext <= ref_d; // [RQ2]
			ctrl.channel <= chs_d; // [RQ4]
			ctrl.start <= start_d; // [RQ5]
			ctrl.abort <= abort_d; // [RQ10]
			ctrl.acq_start <= acq_d; // [RQ10]
		end
	end

	// checks
	localparam int HOLD_MAX = 330;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_go_write;
		state_q == adc_pkg::st_idle && go_wr1 && pwr_q && pwr_d;
	endsequence

	sequence s_start_pulse;
		ctrl.start ##1 !ctrl.start;
	endsequence

	sequence s_abort;
		state_q == adc_pkg::st_convert && go_wr0 && !conv_done;
	endsequence

	sequence s_done;
		state_q == adc_pkg::st_convert && conv_done;
	endsequence

	property p_right_just;
		s_done and just_q |=> result_q == {6'h0, $past(conv_data)};
	endproperty

	property p_left_just;
		s_done and !just_q |=> result_q == {$past(conv_data), 6'h0};
	endproperty

	a_justify_right: assert property (p_right_just) // [RQ1]
		else $error("right justified result wrong");

	a_justify_left: assert property (p_left_just) // [RQ1]
		else $error("left justified result wrong");

	a_ref_follow: assert property ( // [RQ2]
		wr_main |=> ctrl.ref_ext == $past(pwdata[`REF_BIT]))
		else $error("reference select not applied");

	a_unused_zero: assert property ( // [RQ3]
		first_acc && !pwrite && hit_main |=> prdata[`UNUSED_BIT] == 1'b0 && pready)
		else $error("unused main bit read nonzero");

	a_channel_index: assert property ( // [RQ4]
		wr_main |=> ctrl.channel == $past(pwdata[`CHS_HI:`CHS_LO]))
		else $error("channel select not applied");

	a_go_starts: assert property ( // [RQ5]
		s_go_write |=> s_start_pulse and go_rd)
		else $error("go write did not start conversion");

	a_go_reads_one: assert property ( // [RQ5]
		first_acc && !pwrite && hit_main && go_rd && !conv_done |=> prdata[`GO_BIT])
		else $error("go read zero while converting");

	a_done_clears: assert property ( // [RQ6]
		s_done |=> !go_rd && state_q == adc_pkg::st_idle)
		else $error("go not cleared at completion");

	a_power_off: assert property ( // [RQ7]
		wr_main && !pwdata[`PWR_BIT] |=> !ctrl.power_on && !go_rd)
		else $error("converter not shut off");

	a_clkcfg_map: assert property ( // [RQ8]
		wr_clk |=> clksel_q == $past(pwdata[`CLKSEL_HI:`CLKSEL_LO])
			&& clk_rd[7] == 1'b0 && clk_rd[3:0] == 4'h0)
		else $error("clock config field wrong");

	a_done_flag_irq: assert property ( // [RQ9]
		s_done and mask_d[`DONE_BIT] |=> stat_q[`DONE_BIT] && irq)
		else $error("done flag or interrupt missing");

	a_abort_keeps: assert property ( // [RQ10]
		s_abort |=> state_q == adc_pkg::st_holdoff && $stable(result_q)
			&& ctrl.abort)
		else $error("abort did not hold result");

	a_abort_delay: assert property ( // [RQ10]
		s_abort |=> !ctrl.acq_start [*4] ##[0:HOLD_MAX] ctrl.acq_start)
		else $error("acquisition restart timing wrong");

	a_hold_stable: assert property ( // [RQ10]
		state_q == adc_pkg::st_holdoff |=> $stable(result_q))
		else $error("result changed during holdoff");

endmodule // adc_control_registers

// ==== adc_core_model.sv ====
`timescale 1ns/10ps
// behavioural converter core: finishes lat+1 cycles after the edge that takes a start pulse
module adc_core_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire adc_pkg::conv_ctrl_s ctrl,
	input wire logic [9:0] sample,
	input wire logic [7:0] lat,
	output logic conv_done,
	output logic [9:0] conv_data
);
	logic busy_q;
	logic [7:0] cnt_q;
	// start, abort and finish of one conversion; data only valid with done
	always @(posedge clk)
	begin
		conv_done <= 1'b0;
		conv_data <= ~conv_data;
		if (!rst_n)
		begin
			busy_q <= 1'b0;
			conv_data <= 10'h2aa;
		end
		else if (ctrl.abort || !ctrl.power_on)
			busy_q <= 1'b0;
		else if (ctrl.start)
		begin
			busy_q <= 1'b1;
			cnt_q <= lat;
		end
		else if (busy_q && cnt_q == 8'h00)
		begin
			busy_q <= 1'b0;
			conv_done <= 1'b1;
			conv_data <= sample;
		end
		else
			cnt_q <= cnt_q - 8'h01;
	end
endmodule // adc_core_model

// ==== adc_control_registers_tb.sv ====
`timescale 1ns/10ps
`include "adc_regs.svh"
module adc_control_registers_tb;
	localparam logic [11:0] A_MAIN = {2'b00, `MAIN_IDX, 2'b00};
	localparam logic [11:0] A_CLK = {2'b00, `CLKCFG_IDX, 2'b00};
	localparam logic [11:0] A_STAT = {2'b00, `STAT_IDX, 2'b00};
	localparam logic [11:0] A_MASK = {2'b00, `MASK_IDX, 2'b00};
	localparam logic [11:0] A_RES = {2'b00, `RESULT_IDX, 2'b00};
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, conv_done, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, res;
	logic [9:0] conv_data, sample, s;
	logic [7:0] lat, r;
	logic [32:0] e;
	adc_pkg::conv_ctrl_s ctrl;
	logic [32:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;
	int n;
	adc_control_registers #(.RAW_W(10), .RC_CYC(4)) u_dut (.clk(clk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done),
		.conv_data(conv_data), .ctrl(ctrl), .irq(irq));
	adc_core_model u_core (.clk(clk), .rst_n(rst_n), .ctrl(ctrl), .sample(sample),
		.lat(lat), .conv_done(conv_done), .conv_data(conv_data));
	// clock
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		tests_run++;
		if (seen !== want)
		begin
			error_cnt++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// one apb transfer; the expected answer is queued first
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
		input logic [32:0] x);
		int k;
		exp_q.push_back(x);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= w ? d : 32'h0;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k == 20)
		begin
			chk(32'h0, 32'h1);
			results;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic err);
		apb(a, 1'b1, d, {err, 32'h0});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic err);
		apb(a, 1'b0, 32'h0, {err, x});
	endtask
	task automatic wait_irq(input logic v);
		int k;
		k = 0;
		while (irq !== v && k < 400)
		begin
			@(posedge clk);
			k++;
		end
		chk(32'(irq), 32'(v));
		if (k == 400)
			results;
	endtask
	// watcher: takes the oldest note whenever an answer appears
	always @(posedge clk)
		if (psel && penable && pready)
		begin
			e = exp_q.pop_front();
			chk(32'(pslverr), 32'(e[32]));
			if (!pwrite)
				chk(prdata, e[31:0]);
		end
	// main sequence
	initial
	begin
		rst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		sample = 10'h0;
		lat = 8'd30;
		void'($urandom(32'h4cc5d993));
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rd(A_MAIN, 32'h00, 1'b0);
		rd(A_CLK, 32'h00, 1'b0);
		rd(A_STAT, 32'h00, 1'b0);
		wr(A_MAIN, 32'hff, 1'b0);
		rd(A_MAIN, 32'hdd, 1'b0);
		chk(32'(ctrl.power_on), 32'h1);
		for (int i = 0; i < 8; i++)
		begin
			r = 8'($urandom) & 8'hc0;
			wr(A_MAIN, 32'(r | 8'(i << 2) | 8'h01), 1'b0);
			chk(32'(ctrl.channel), i);
			chk(32'(ctrl.ref_ext), 32'(r[6]));
			rd(A_MAIN, 32'(r | 8'(i << 2) | 8'h01), 1'b0);
		end
		wr(A_CLK, 32'hff, 1'b0);
		rd(A_CLK, 32'h70, 1'b0);
		wr(A_CLK, 32'h00, 1'b0);
		wr(12'h3fc, 32'h55, 1'b1);
		rd(12'h3fc, 32'h00, 1'b1);
		wr(A_MASK, 32'h01, 1'b0);
		// one conversion in each justification
		for (int j = 0; j < 2; j++)
		begin
			s = 10'($urandom);
			sample <= s;
			wr(A_MAIN, 32'((j << 7) | 3), 1'b0);
			rd(A_MAIN, 32'((j << 7) | 3), 1'b0);
			wait_irq(1'b1);
			rd(A_MAIN, 32'((j << 7) | 1), 1'b0);
			res = j ? {22'h0, s} : {16'h0, s, 6'h0};
			rd(A_RES, res, 1'b0);
			rd(A_STAT, 32'h01, 1'b0);
			wr(A_STAT, 32'h01, 1'b0);
			wait_irq(1'b0);
		end
		// abort in mid-conversion, at the fastest and at a random clock select
		lat <= 8'd200;
		for (int c = 0; c < 2; c++)
		begin
			wr(A_CLK, 32'(c ? (8'($urandom) & 8'h70) : 8'h00), 1'b0);
			wr(A_MAIN, 32'h83, 1'b0);
			wr(A_MAIN, 32'h81, 1'b0);
			n = 0;
			do
			begin
				@(posedge clk);
				n++;
			end
			while (ctrl.acq_start !== 1'b1 && n < 200);
			chk(32'(ctrl.acq_start), 32'h1);
			rd(A_STAT, 32'h02, 1'b0);
			rd(A_RES, res, 1'b0);
			chk(32'(irq), 32'h0);
			wr(A_MASK, 32'h03, 1'b0);
			wait_irq(1'b1);
			wr(A_STAT, 32'h03, 1'b0);
			wait_irq(1'b0);
			wr(A_MASK, 32'h01, 1'b0);
		end
		// power off in mid-conversion aborts it
		wr(A_MAIN, 32'h83, 1'b0);
		wr(A_MAIN, 32'h00, 1'b0);
		chk(32'(ctrl.power_on), 32'h0);
		rd(A_MAIN, 32'h00, 1'b0);
		rd(A_STAT, 32'h02, 1'b0);
		results;
	end
endmodule // adc_control_registers_tb
